/* File: rfcd_pkg.sv */
// Constants and helpers shared by both ends of the RF command link
package rfcd_pkg;
  // ---------------------------------------------------------------
  // Command codes and limits
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_SIZE   = 8'h13;
  localparam logic [7:0] CMD_READ   = 8'h14;
  localparam logic [7:0] CMD_RSVD   = 8'h15;
  localparam logic [7:0] CMD_ON     = 8'h16;
  localparam logic [7:0] CMD_OFF    = 8'h17;
  localparam logic [7:0] CMD_DBG    = 8'h18;
  localparam logic [7:0] ID_LO_MAX  = 8'h1C;
  localparam logic [7:0] ID_HI_MIN  = 8'h80;
  localparam logic [7:0] ID_HI_MAX  = 8'h9C;
  localparam logic [5:0] MAX_ELEM   = 6'h27;
  localparam logic [7:0] ELEM_BYTES = 8'h05;
  localparam logic [2:0] LAST_BSEL  = 3'h4;
  localparam logic [3:0] SEL_MAX    = 4'h7;
  localparam logic [3:0] SEL_CLK    = 4'h8;
  localparam logic [3:0] PIN_MAX    = 4'h3;
  localparam logic [2:0] ONE_PARAM  = 3'h2;
  localparam logic [2:0] DBG_MIN    = 3'h3;
  localparam logic [2:0] DBG_MAX    = 3'h6;
  localparam int         MAX_FRAME  = 6;
  localparam int         NUM_PINS   = 4;
  localparam int         NUM_SIG    = 56;
  localparam int         BIT_NO_CA  = 0;
  localparam int         BIT_ACTIVE = 1;
  localparam logic [2:0] GRP_NONE   = 3'h7;
  // ---------------------------------------------------------------
  // Controller registers
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_TX0  = 12'h004;
  localparam logic [11:0] REG_TX1  = 12'h008;
  localparam logic [11:0] REG_RX   = 12'h00C;
  localparam logic [11:0] REG_STAT = 12'h010;
  localparam logic [11:0] REG_MASK = 12'h014;
  localparam int          ST_DONE  = 0;
  localparam int          ST_ERR   = 1;
  localparam int          ST_RX    = 2;
  localparam int          ST_W     = 3;
  localparam int          BUSY_BIT = 8;
  localparam logic [31:0] REG_RST  = 32'h0000_0000;

  // Group code to index; GRP_NONE marks an unknown code
  function automatic logic [2:0] grp_idx(input logic [7:0] code);
    case (code)
      8'h01:   grp_idx = 3'h0;
      8'h1B:   grp_idx = 3'h1;
      8'h1D:   grp_idx = 3'h2;
      8'h30:   grp_idx = 3'h3;
      8'h58:   grp_idx = 3'h4;
      8'h70:   grp_idx = 3'h5;
      8'h73:   grp_idx = 3'h6;
      default: grp_idx = GRP_NONE;
    endcase
  endfunction

  function automatic logic id_ok(input logic [7:0] id);
    id_ok = (id <= ID_LO_MAX) || (id >= ID_HI_MIN && id <= ID_HI_MAX);
  endfunction
endpackage

/* File: rfcd_link_if.sv */
// Byte-stream link between host controller and RF command device
`timescale 1ns/1ps
interface rfcd_link_if (
  input logic pclk,
  input logic presetn
);
  logic       cmd_valid;
  logic       cmd_ready;
  logic       cmd_last;
  logic [7:0] cmd_byte;
  logic       rsp_valid;
  logic       rsp_ready;
  logic [7:0] rsp_byte;
  logic       done;
  logic       error;

  modport dev (
    input  pclk, presetn, cmd_valid, cmd_last, cmd_byte, rsp_ready,
    output cmd_ready, rsp_valid, rsp_byte, done, error
  );
  modport ctl (
    input  pclk, presetn, cmd_ready, rsp_valid, rsp_byte, done, error,
    output cmd_valid, cmd_last, cmd_byte, rsp_ready
  );
endinterface

/* File: rfcd_device.sv */
// Device end: command parser, config readout, field and debug bus
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module rfcd_device
  import rfcd_pkg::*;
(
  rfcd_link_if.dev          link,
  input  wire logic         field_on_en,
  input  wire logic         field_off_en,
  input  wire logic [1:0]   flag_clear,
  input  wire logic         debug_bus_allow,
  input  wire logic         clk13_in,
  input  wire logic [55:0]  dbg_in,
  input  wire logic [5:0]   cfg_count,
  input  wire logic [7:0]   cfg_addr,
  input  wire logic [31:0]  cfg_word,
  output logic [7:0]        cfg_id,
  output logic [5:0]        cfg_idx,
  output logic              field_on,
  output logic              no_coll_avoid,
  output logic              active_mode,
  output logic              field_on_flag,
  output logic              field_off_flag,
  output logic              irq_pin,
  output logic              aux_pin_one,
  output logic              aux_pin_two,
  output logic              general_output_one
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_RECV  = 3'b001,
    S_CHECK = 3'b010,
    S_SEND  = 3'b011,
    S_DONE  = 3'b100
  } rfcd_dev_state_e;

  logic            pclk;
  logic            presetn;
  rfcd_dev_state_e state;
  logic [7:0]      frame [0:MAX_FRAME-1];
  logic [2:0]      nbytes;
  logic            ovf;
  logic            ok;
  logic            err_hold;
  logic            is_size;
  logic [7:0]      left;
  logic [2:0]      bsel;
  logic [5:0]      nelem;
  logic            field_prev;
  logic [56:0]     sync1;
  logic [56:0]     sync2;
  logic            pin_vld [0:NUM_PINS-1];
  logic [2:0]      pin_grp [0:NUM_PINS-1];
  logic [3:0]      pin_sel [0:NUM_PINS-1];
  logic [NUM_PINS-1:0] pin_q;
  logic            take;
  logic            emit;

  assign pclk    = link.pclk;
  assign presetn = link.presetn;
  assign take    = link.cmd_valid && link.cmd_ready;
  assign emit    = (left != 8'h00) && (!link.rsp_valid || link.rsp_ready);
  assign nelem   = (cfg_count > MAX_ELEM) ? MAX_ELEM : cfg_count;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  always_comb begin
    ok = 1'b0;
    case (frame[0])
      CMD_SIZE, CMD_READ: ok = (nbytes == ONE_PARAM) && id_ok(frame[1]);
      CMD_RSVD: ok = 1'b1;
      CMD_ON, CMD_OFF: ok = (nbytes == ONE_PARAM);
      CMD_DBG: begin
        ok = (nbytes >= DBG_MIN) && (nbytes <= DBG_MAX)
             && (grp_idx(frame[1]) != GRP_NONE);
        for (int i = 2; i < MAX_FRAME; i++) begin
          if (i < int'(nbytes) && (frame[i][7:4] > PIN_MAX
              || frame[i][3:0] > SEL_CLK)) begin
            ok = 1'b0;
          end
        end
      end
      default: ok = 1'b0;
    endcase
    if (ovf) begin
      ok = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= S_IDLE;
      link.cmd_ready <= 1'b0;
      link.done      <= 1'b0;
      link.error     <= 1'b0;
      err_hold       <= 1'b0;
    end else begin
      link.done <= 1'b0;
      case (state)
        S_IDLE: begin
          link.cmd_ready <= 1'b1;
          if (take) begin
            state <= link.cmd_last ? S_CHECK : S_RECV;
            link.cmd_ready <= !link.cmd_last;
          end
        end
        S_RECV: begin
          if (take && link.cmd_last) begin
            state          <= S_CHECK;
            link.cmd_ready <= 1'b0;
          end
        end
        S_CHECK: begin
          err_hold <= !ok;
          if (ok && (frame[0] == CMD_SIZE || frame[0] == CMD_READ)) begin
            state <= S_SEND;
          end else begin
            state <= S_DONE;
          end
        end
        S_SEND: begin
          if (left == 8'h00 && (!link.rsp_valid || link.rsp_ready)) begin
            state <= S_DONE;
          end
        end
        S_DONE: begin
          link.done  <= 1'b1;
          link.error <= err_hold;
          state      <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Frame capture
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nbytes <= 3'h0;
      ovf    <= 1'b0;
      cfg_id <= 8'h00;
      for (int i = 0; i < MAX_FRAME; i++) begin
        frame[i] <= 8'h00;
      end
    end else if (take) begin
      if (state == S_IDLE) begin
        frame[0] <= link.cmd_byte;
        nbytes   <= 3'h1;
        ovf      <= 1'b0;
      end else if (int'(nbytes) < MAX_FRAME) begin
        frame[nbytes] <= link.cmd_byte;
        nbytes        <= nbytes + 3'h1;
        if (nbytes == 3'h1) begin
          cfg_id <= link.cmd_byte;
        end
      end else begin
        ovf <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Response stream
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left           <= 8'h00;
      bsel           <= 3'h0;
      cfg_idx        <= 6'h00;
      is_size        <= 1'b0;
      link.rsp_valid <= 1'b0;
      link.rsp_byte  <= 8'h00;
    end else if (state == S_CHECK) begin
      bsel    <= 3'h0;
      cfg_idx <= 6'h00;
      is_size <= (frame[0] == CMD_SIZE);
      if (ok && frame[0] == CMD_SIZE) begin
        left <= 8'h01;
      end else if (ok && frame[0] == CMD_READ) begin
        left <= 8'(nelem * ELEM_BYTES);
      end else begin
        left <= 8'h00;
      end
    end else if (emit) begin
      link.rsp_valid <= 1'b1;
      left           <= left - 8'h01;
      if (is_size) begin
        link.rsp_byte <= {2'b00, cfg_count};
      end else if (bsel == 3'h0) begin
        link.rsp_byte <= cfg_addr;
      end else begin
        link.rsp_byte <= cfg_word[8*(bsel-3'h1) +: 8];
      end
      if (bsel == LAST_BSEL) begin
        bsel    <= 3'h0;
        cfg_idx <= cfg_idx + 6'h01;
      end else begin
        bsel <= bsel + 3'h1;
      end
    end else if (link.rsp_ready) begin
      link.rsp_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // RF field and flags
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_on      <= 1'b0;
      no_coll_avoid <= 1'b0;
      active_mode   <= 1'b0;
    end else if (state == S_CHECK && ok) begin
      if (frame[0] == CMD_ON) begin
        field_on      <= 1'b1;
        no_coll_avoid <= frame[1][BIT_NO_CA];
        active_mode   <= frame[1][BIT_ACTIVE];
      end else if (frame[0] == CMD_OFF) begin
        field_on <= 1'b0;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_prev     <= 1'b0;
      field_on_flag  <= 1'b0;
      field_off_flag <= 1'b0;
    end else begin
      field_prev <= field_on;
      if (field_on && !field_prev && field_on_en) begin
        field_on_flag <= 1'b1;
      end else if (flag_clear[0]) begin
        field_on_flag <= 1'b0;
      end
      if (!field_on && field_prev && field_off_en) begin
        field_off_flag <= 1'b1;
      end else if (flag_clear[1]) begin
        field_off_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Debug bus
  // ---------------------------------------------------------------
  // Probe sources are asynchronous, so all pass two stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {clk13_in, dbg_in};
      sync2 <= sync1;
    end
  end

  // Pins not named in a command keep their earlier selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_vld[p] <= 1'b0;
        pin_grp[p] <= 3'h0;
        pin_sel[p] <= 4'h0;
      end
    end else if (state == S_CHECK && ok && frame[0] == CMD_DBG) begin
      for (int i = 2; i < MAX_FRAME; i++) begin
        if (i < int'(nbytes)) begin
          pin_vld[frame[i][5:4]] <= 1'b1;
          pin_grp[frame[i][5:4]] <= grp_idx(frame[1]);
          pin_sel[frame[i][5:4]] <= frame[i][3:0];
        end
      end
    end
  end

  // Each pin has its own selector; sampled clock is a coarse copy
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic sig;
    logic idle_lvl;
    assign sig = (pin_sel[p] == SEL_CLK) ? sync2[NUM_SIG]
                 : sync2[{pin_grp[p], pin_sel[p][2:0]}];
    assign idle_lvl = (p == 0) ? (field_on_flag | field_off_flag) : 1'b0;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_q[p] <= 1'b0;
      end else begin
        pin_q[p] <= (debug_bus_allow && pin_vld[p]) ? sig
                    : idle_lvl;
      end
    end
  end

  assign irq_pin            = pin_q[0];
  assign aux_pin_one        = pin_q[1];
  assign aux_pin_two        = pin_q[2];
  assign general_output_one = pin_q[3];
endmodule

/* File: rfcd_host.sv */
// Host end: APB register front that drives the command link
`timescale 1ns/1ps
module rfcd_host
  import rfcd_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output logic              irq,
  rfcd_link_if.ctl          link
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_SEND = 2'b01,
    H_WAIT = 2'b10
  } rfcd_host_state_e;

  rfcd_host_state_e state;
  logic [31:0]      tx0;
  logic [31:0]      tx1;
  logic [2:0]       len;
  logic [2:0]       idx;
  logic [ST_W-1:0]  status;
  logic [ST_W-1:0]  mask;
  logic [ST_W-1:0]  next_status;
  logic [7:0]       rx_byte;
  logic             rx_full;
  logic             next_rx_full;
  logic             acc;
  logic             wr;
  logic             rd_rx;
  logic             busy;
  logic             got;
  logic [63:0]      txall;

  assign acc   = psel && penable && pready;
  assign wr    = acc && pwrite;
  assign rd_rx = acc && !pwrite && paddr == REG_RX;
  assign busy  = (state != H_IDLE);
  assign got   = link.rsp_valid && link.rsp_ready;
  assign txall = {tx1, tx0};

  // ---------------------------------------------------------------
  // APB slave, one wait state
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= REG_RST;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          REG_CTRL: prdata <= {23'h0, busy, 5'h0, len};
          REG_TX0:  prdata <= tx0;
          REG_TX1:  prdata <= tx1;
          REG_RX:   prdata <= {23'h0, rx_full, rx_byte};
          REG_STAT: prdata <= {28'h0, busy, status};
          REG_MASK: prdata <= {29'h0, mask};
          default:  prdata <= REG_RST;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx0  <= REG_RST;
      tx1  <= REG_RST;
      len  <= 3'h0;
      mask <= '0;
    end else if (wr) begin
      case (paddr)
        REG_TX0:  tx0 <= pwdata;
        REG_TX1:  tx1 <= pwdata;
        REG_MASK: mask <= pwdata[ST_W-1:0];
        REG_CTRL: begin
          if (!busy) begin
            len <= pwdata[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command sender
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state          <= H_IDLE;
      idx            <= 3'h0;
      link.cmd_valid <= 1'b0;
      link.cmd_last  <= 1'b0;
      link.cmd_byte  <= 8'h00;
    end else begin
      case (state)
        H_IDLE: begin
          idx <= 3'h0;
          if (wr && paddr == REG_CTRL && pwdata[2:0] != 3'h0) begin
            state <= H_SEND;
          end
        end
        H_SEND: begin
          if (!link.cmd_valid || link.cmd_ready) begin
            if (link.cmd_valid && link.cmd_last) begin
              link.cmd_valid <= 1'b0;
              link.cmd_last  <= 1'b0;
              state          <= H_WAIT;
            end else begin
              link.cmd_valid <= 1'b1;
              link.cmd_byte  <= txall[8*idx +: 8];
              link.cmd_last  <= (idx == len - 3'h1);
              idx            <= idx + 3'h1;
            end
          end
        end
        H_WAIT: begin
          if (link.done) begin
            state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Response holding and status
  // ---------------------------------------------------------------
  // Single holding byte; link stalls until software reads it
  always_comb begin
    next_rx_full = rx_full;
    if (got) begin
      next_rx_full = 1'b1;
    end else if (rd_rx) begin
      next_rx_full = 1'b0;
    end
    next_status = status;
    if (wr && paddr == REG_STAT) begin
      next_status = status & ~pwdata[ST_W-1:0];
    end
    next_status[ST_DONE] = next_status[ST_DONE] | link.done;
    next_status[ST_ERR]  = next_status[ST_ERR] | (link.done & link.error);
    next_status[ST_RX]   = next_status[ST_RX] | got;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full        <= 1'b0;
      rx_byte        <= 8'h00;
      link.rsp_ready <= 1'b0;
      status         <= '0;
      irq            <= 1'b0;
    end else begin
      rx_full        <= next_rx_full;
      link.rsp_ready <= !next_rx_full;
      status         <= next_status;
      irq            <= |(next_status & mask);
      if (got) begin
        rx_byte <= link.rsp_byte;
      end
    end
  end
endmodule

/* File: rfcd_link_properties.sv */
// Protocol checker for the byte link between host and device ends
`timescale 1ns/1ps
module rfcd_link_properties
  import rfcd_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cmd_valid,
  input wire logic       cmd_ready,
  input wire logic       cmd_last,
  input wire logic [7:0] cmd_byte,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic [7:0] rsp_byte,
  input wire logic       done,
  input wire logic       error
);
  logic       take;
  logic       first;
  logic       id_good;
  logic [7:0] opc;
  logic [7:0] cur;
  logic [2:0] nb;
  assign take = cmd_valid && cmd_ready;
  assign cur = first ? cmd_byte : opc;
  assign id_good = cmd_byte <= ID_LO_MAX ||
                   (cmd_byte >= ID_HI_MIN && cmd_byte <= ID_HI_MAX);
  // ------
  // Frame tracking, so a rule can name the byte position
  // ------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first <= 1'h1;
      opc   <= 8'h00;
      nb    <= 3'h0;
    end else if (take) begin
      first <= cmd_last;
      nb    <= cmd_last ? 3'h0 : nb + 3'h1;
      if (first)
        opc <= cmd_byte;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_size_bad;
    take && cmd_last && cur == CMD_SIZE && nb == 3'h1 && !id_good
      |-> ##[1:4] (done && error);
  endproperty
  a_size_bad: assert property (p_size_bad) else $error("bad id accepted");
  property p_size_one;
    take && cmd_last && cur == CMD_SIZE && nb == 3'h1 && id_good
      |-> ##[1:4] (rsp_valid && rsp_byte[7:6] == 2'h0);
  endproperty
  a_size_one: assert property (p_size_one) else $error("no size byte");
  property p_rsvd;
    take && cmd_last && cur == CMD_RSVD
      |-> !rsp_valid throughout (##[1:4] (done && !error));
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code misused");
  property p_off;
    take && cmd_last && cur == CMD_OFF && nb == 3'h1
      |-> !rsp_valid [*3] ##1 (done && !error);
  endproperty
  a_off: assert property (p_off) else $error("field off misframed");
  property p_dbg_pin;
    take && cmd_last && cur == CMD_DBG && nb >= 3'h2
      && cmd_byte[7:4] > PIN_MAX |-> ##[1:4] (done && error);
  endproperty
  a_dbg_pin: assert property (p_dbg_pin) else $error("bad pin taken");
  property p_dbg_sel;
    take && cmd_last && cur == CMD_DBG && nb >= 3'h2
      && cmd_byte[3:0] > SEL_CLK |-> ##[1:4] (done && error);
  endproperty
  a_dbg_sel: assert property (p_dbg_sel) else $error("bad signal taken");
  property p_rsp_hold;
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("rsp byte lost");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_err_hold;
    !done |-> $stable(error);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error moved");
  c_read: cover property (take && cmd_last && cur == CMD_READ);
  c_on: cover property (take && cmd_last && cur == CMD_ON);
  c_fail: cover property (done && error);
endmodule

/* File: rfcd_test.sv */
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module rfcd_test
  import rfcd_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        on_en, off_en, allow, clk13, msk, ok;
  logic        fon, nca, act, fon_f, foff_f, ipin, ax1, ax2, gpo;
  logic [1:0]  fclr;
  logic [3:0]  sb[4];
  logic [5:0]  cnt, cfg_idx, c6;
  logic [7:0]  cfg_id, id;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [47:0] fr;
  logic [55:0] dbg;
  logic [63:0] dv;
  logic [8:0]  exp_q[$];
  int          err_total, num_checks, seed;
  logic [7:0]  ids[8] = '{8'h00, 8'h1C, 8'h1D, 8'h7F, 8'h80, 8'h9C, 8'h9D,
                          8'hFF};
  logic [7:0]  gc[7] = '{8'h01, 8'h1B, 8'h1D, 8'h30, 8'h58, 8'h70, 8'h73};
  logic [47:0] fb[10] = '{48'h15, 48'h3315, 48'h20, 48'h16, 48'h000316,
                          48'h100218, 48'h400118, 48'h090118, 48'h9D14,
                          48'h0118};
  int          ln[10] = '{1, 2, 1, 1, 3, 3, 3, 3, 2, 2};
  int          cs[3] = '{41, 0, 2};
  wire  [7:0]  c_addr = {2'h0, cfg_idx} + 8'h40;
  wire  [31:0] c_word = {cfg_id, 2'h0, cfg_idx, 8'h5A, ~cfg_id};
  rfcd_link_if link (.pclk(pclk), .presetn(presetn));
  rfcd_host i_rfcd_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link));
  rfcd_device i_rfcd_device (.link(link), .field_on_en(on_en),
    .field_off_en(off_en), .flag_clear(fclr), .debug_bus_allow(allow),
    .clk13_in(clk13), .dbg_in(dbg), .cfg_count(cnt), .cfg_addr(c_addr),
    .cfg_word(c_word), .cfg_id(cfg_id), .cfg_idx(cfg_idx), .field_on(fon),
    .no_coll_avoid(nca), .active_mode(act), .field_on_flag(fon_f),
    .field_off_flag(foff_f), .irq_pin(ipin), .aux_pin_one(ax1),
    .aux_pin_two(ax2), .general_output_one(gpo));
  rfcd_link_properties i_props (.pclk(pclk), .presetn(presetn),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
    .cmd_last(link.cmd_last), .cmd_byte(link.cmd_byte),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
    .rsp_byte(link.rsp_byte), .done(link.done), .error(link.error));
  // ------
  // Checking and bus tasks
  // ------
  task end_of_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task fail_out();
    err_total++;
    end_of_test();
  endtask
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task note(input logic [8:0] v);
    exp_q.push_back(v);
  endtask
  task cmp(input logic [8:0] g);
    chk("link", exp_q.size() > 0 ? exp_q.pop_front() : 9'h1FF, g);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 64);
    rd = prdata;
    chk("pslverr", 9'h0, 9'(pslverr));
    psel    <= 1'h0;
    penable <= 1'h0;
    if (k >= 64) fail_out();
  endtask
  // RX is read only to free the host; the link monitor checks bytes
  task automatic send(input logic [47:0] b, input logic [2:0] n);
    int k = 0;
    apb(1'h1, REG_TX0, b[31:0]);
    apb(1'h1, REG_TX1, {16'h0, b[47:32]});
    apb(1'h1, REG_CTRL, {29'h0, n});
    do begin
      apb(1'h0, REG_RX, 32'h0);
      apb(1'h0, REG_STAT, 32'h0);
      k++;
    end while (rd[ST_DONE] !== 1'h1 && k < 400);
    if (k >= 400) fail_out();
    apb(1'h0, REG_RX, 32'h0);
    chk("irq", 9'(msk), 9'(irq));
    apb(1'h1, REG_STAT, 32'h7);
    repeat (2) @(posedge pclk);
    chk("irq", 9'h0, 9'(irq));
  endtask
  always @(posedge pclk) begin
    if (presetn && link.rsp_valid && link.rsp_ready) cmp({1'h0, link.rsp_byte});
    if (presetn && link.done) cmp({1'h1, 7'h0, link.error});
  end
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, fclr} = '0;
    {on_en, off_en, allow, clk13, dbg, cnt, msk} = '0;
    seed = 39;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, REG_MASK, 32'h0);
    chk("mask", 9'h0, rd[8:0]);
    apb(1'h1, REG_MASK, 32'h1);
    msk = 1'h1;
    for (int i = 0; i < 8; i++) begin
      ok = ids[i] <= 8'h1C || (ids[i] >= 8'h80 && ids[i] <= 8'h9C);
      c6 = 6'($random(seed));
      cnt <= c6;
      if (ok) note({3'h0, c6});
      note({1'h1, 7'h0, !ok});
      send({32'h0, ids[i], CMD_SIZE}, 3'h2);
    end
    apb(1'h1, REG_MASK, 32'h0);
    msk = 1'h0;
    // Size query always precedes readout in this sequence
    for (int i = 0; i < 3; i++) begin
      cnt <= 6'(cs[i]);
      id = 8'h80 + 8'(i * 14);
      note({3'h0, 6'(cs[i])});
      note(9'h100);
      send({32'h0, id, CMD_SIZE}, 3'h2);
      for (int e = 0; e < cs[i] && e < 39; e++) begin
        note({1'h0, 8'h40 + 8'(e)});
        note({1'h0, ~id});
        note(9'h05A);
        note({3'h0, 6'(e)});
        note({1'h0, id});
      end
      note(9'h100);
      send({32'h0, id, CMD_READ}, 3'h2);
    end
    for (int i = 0; i < 10; i++) begin
      note({1'h1, 7'h0, i > 1});
      send(fb[i], 3'(ln[i]));
    end
    chk("no action", 9'h0, 9'(fon));
    for (int p = 0; p < 4; p++) begin
      on_en  <= p[0];
      off_en <= p[1];
      fclr   <= 2'h3;
      @(posedge pclk);
      fclr   <= 2'h0;
      note(9'h100);
      send({40'h0, 8'(p), CMD_ON}, 3'h2);
      chk("mode", 9'({1'h1, 2'(p)}), 9'({fon, act, nca}));
      chk("on flag", 9'(p[0]), 9'(fon_f));
      note(9'h100);
      send({32'h0, 8'($random(seed)), CMD_OFF}, 3'h2);
      chk("off", 9'({1'h0, p[1]}), 9'({fon, foff_f}));
    end
    fclr <= 2'h3;
    dbg  <= {56{1'h1}};
    note(9'h100);
    send(48'h302010000118, 3'h6);
    repeat (8) @(posedge pclk);
    chk("pins off", 9'h0, 9'({gpo, ax2, ax1, ipin}));
    allow <= 1'h1;
    repeat (8) @(posedge pclk);
    chk("pins on", 9'h00F, 9'({gpo, ax2, ax1, ipin}));
    for (int g = 0; g < 7; g++) begin
      dv = {$random(seed), $random(seed)};
      dbg   <= dv[55:0];
      clk13 <= dv[63];
      for (int p = 0; p < 4; p++)
        sb[p] = (p == g % 4) ? 4'h8 : 4'($random(seed) & 7);
      fr = {4'h3, sb[3], 4'h2, sb[2], 4'h1, sb[1], 4'h0, sb[0], gc[g],
            CMD_DBG};
      note(9'h100);
      send(fr, 3'h6);
      repeat (8) @(posedge pclk);
      for (int p = 0; p < 4; p++)
        chk("pin", 9'(sb[p] == 4'h8 ? dv[63] : dv[g * 8 + sb[p]]),
            9'(({gpo, ax2, ax1, ipin} >> p) & 4'h1));
    end
    chk("queue", 9'h0, 9'(exp_q.size()));
    end_of_test();
  end
endmodule
